// ===== hw/abort_fault_status_capture.sv
// Behaviour
// RULE1: each data abort overwrites the data abort status register with its cause.
// RULE2: each instruction abort overwrites the instruction abort status register with its cause.
// RULE3: both registers are reached only from privileged mode and user accesses are refused.
// RULE4: the data register sits at coprocessor 15, c5, c0, opcode2 0.
// RULE5: the instruction register sits at coprocessor 15, c5, c0, opcode2 1.
// RULE6: bit 12 holds zero for a decode error and one for a slave error on external aborts.
// RULE7: bit 12 is written as zero for every abort that is not external.
// RULE8: a data abort from an exclusive read answered okay sets bit 12 like a slave error.
// RULE9: bit 11 of the data register is zero for a read and one for a write abort.
// RULE10: bits 9 to 8 of the data register read as zero and ignore writes.
// RULE11: bits 7 to 4 of both registers are never set by the hardware.
// RULE12: the data fault type is held jointly in bit 10 and bits 3 to 0, qualified by bit 12.
// RULE13: the instruction fault type is held the same way in bit 10, bits 3 to 0 and bit 12.
// RULE14: the five bit fault type codes are fixed per abort kind.
// RULE15: reserved fault type codes are never produced by the hardware.
// RULE16: a privileged write loads the writable fields and leaves fixed zero bits at zero.
`timescale 1ns/100ps
`default_nettype none
`include "abort_status_map.svh"

module abort_fault_status_capture
	import abort_status_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire abort_event_t data_abort_i,
	input wire abort_event_t instr_abort_i,
	input wire cp_access_t cp_access_i,
	output logic cp_accept_o,
	output logic cp_refuse_o,
	output logic [31:0] cp_rdata_o,
	output logic [31:0] data_abort_status_o,
	output logic [31:0] instruction_abort_status_o
);

	logic [31:0] data_abort_status_reg;
	logic [31:0] data_abort_status_next;
	logic [31:0] instruction_abort_status_reg;
	logic [31:0] instruction_abort_status_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] data_word;
	logic [31:0] instr_word;
	logic sel_data;
	logic sel_instr;
	logic hit;
	logic priv_ok;
	logic data_wr_en;
	logic instr_wr_en;
	logic rd_en;

	// only the listed kinds map to codes, so reserved codes cannot appear
	function automatic logic [4:0] type_code(input abort_kind_t k);
		case (k)
			ABT_ALIGN: type_code = `FT_ALIGN; // RULE14
			ABT_BACKGROUND: type_code = `FT_BACKGROUND;
			ABT_PERMISSION: type_code = `FT_PERMISSION;
			ABT_PRECISE_EXT: type_code = `FT_PRECISE_EXT;
			ABT_IMPRECISE_EXT: type_code = `FT_IMPRECISE_EXT;
			ABT_PRECISE_ECC: type_code = `FT_PRECISE_ECC;
			ABT_IMPRECISE_ECC: type_code = `FT_IMPRECISE_ECC;
			ABT_DEBUG: type_code = `FT_DEBUG;
			default: type_code = `FT_DEBUG; // RULE15
		endcase
	endfunction

	function automatic logic is_external(input abort_kind_t k);
		is_external = (k == ABT_PRECISE_EXT) || (k == ABT_IMPRECISE_EXT);
	endfunction

	// error class only means something for external aborts
	function automatic logic err_class_of(input abort_event_t e, input logic with_dir);
		logic slave;
		slave = (e.resp == RESP_SLVERR); // RULE6
		if (with_dir && e.excl_read && (e.resp == RESP_OKAY))
		begin
			slave = 1'h1; // RULE8
		end
		err_class_of = is_external(e.kind) ? slave : 1'h0; // RULE7
	endfunction

	// builds a status word; domain bits 7:4 and bits 9:8 always zero
	function automatic logic [31:0] build_status(input abort_event_t e, input logic with_dir);
		logic [4:0] code;
		logic err_class;
		logic dir;
		code = type_code(e.kind);
		err_class = err_class_of(e, with_dir);
		dir = with_dir & e.is_write; // RULE9
		build_status = `STATUS_RESET; // RULE11
		build_status[`ERR_CLASS_BIT] = err_class;
		build_status[`DIR_BIT] = dir;
		build_status[`TYPE_HI_BIT] = code[4]; // RULE12 RULE13
		build_status[3:0] = code[3:0];
	endfunction

	// data aborts carry the direction and the exclusive-read case
	function automatic logic [31:0] data_status_word(input abort_event_t e);
		data_status_word = build_status(e, 1'h1);
	endfunction

	// instruction aborts never report a direction, so bit 11 stays zero
	function automatic logic [31:0] instr_status_word(input abort_event_t e);
		instr_status_word = build_status(e, 1'h0);
	endfunction

	// other coprocessor addresses are ignored here, not refused
	function automatic logic reg_select(input cp_access_t a, input logic [2:0] op2);
		logic addr_ok;
		addr_ok = a.valid;
		addr_ok = addr_ok && (a.cp_num == `SCP_NUM);
		addr_ok = addr_ok && (a.opc1 == `SCP_OP1);
		addr_ok = addr_ok && (a.crn == `SCP_CRN);
		addr_ok = addr_ok && (a.crm == `SCP_CRM);
		reg_select = addr_ok && (a.opc2 == op2);
	endfunction

	// fixed-zero bits are dropped at the write so a read never shows them
	function automatic logic [31:0] masked_load(input logic [31:0] d, input logic [31:0] m);
		masked_load = d & m;
	endfunction

	// user-mode hits are refused rather than ignored, so the core can trap them
	always_comb
	begin
		sel_data = reg_select(cp_access_i, `SCP_OP2_DATA); // RULE4
		sel_instr = reg_select(cp_access_i, `SCP_OP2_INSTR); // RULE5
		hit = sel_data || sel_instr;
		priv_ok = cp_access_i.privileged; // RULE3
		cp_accept_o = hit && priv_ok;
		cp_refuse_o = hit && !priv_ok; // RULE3
	end

	always_comb
	begin
		data_wr_en = cp_accept_o && cp_access_i.write && sel_data;
		instr_wr_en = cp_accept_o && cp_access_i.write && sel_instr;
		rd_en = cp_accept_o && !cp_access_i.write;
		data_word = data_status_word(data_abort_i);
		instr_word = instr_status_word(instr_abort_i);
	end

	// an abort in the same cycle as a software write wins, keeping the latest cause
	always_comb
	begin
		data_abort_status_next = data_abort_status_reg;
		if (data_wr_en)
		begin
			data_abort_status_next = masked_load(cp_access_i.wdata, `DATA_WR_MASK); // RULE16 RULE10
		end
		if (data_abort_i.valid)
		begin
			data_abort_status_next = data_word; // RULE1
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			data_abort_status_reg <= `STATUS_RESET;
		end
		else
		begin
			data_abort_status_reg <= data_abort_status_next;
		end
	end

	always_comb
	begin
		instruction_abort_status_next = instruction_abort_status_reg;
		if (instr_wr_en)
		begin
			instruction_abort_status_next = masked_load(cp_access_i.wdata, `INSTR_WR_MASK); // RULE16
		end
		if (instr_abort_i.valid)
		begin
			instruction_abort_status_next = instr_word; // RULE2
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			instruction_abort_status_reg <= `STATUS_RESET;
		end
		else
		begin
			instruction_abort_status_reg <= instruction_abort_status_next;
		end
	end

	// a read returns the value held before any update landing in the same cycle
	always_comb
	begin
		rdata_next = rdata_reg;
		if (rd_en)
		begin
			rdata_next = sel_data ? data_abort_status_reg : instruction_abort_status_reg;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rdata_reg <= `STATUS_RESET;
		end
		else
		begin
			rdata_reg <= rdata_next;
		end
	end

	assign cp_rdata_o = rdata_reg;
	assign data_abort_status_o = data_abort_status_reg;
	assign instruction_abort_status_o = instruction_abort_status_reg;

endmodule

`default_nettype wire

// ===== hw/abort_status_map.svh
`ifndef ABORT_STATUS_MAP_SVH
`define ABORT_STATUS_MAP_SVH

// coprocessor selectors
`define SCP_NUM 4'hf
`define SCP_CRN 4'h5
`define SCP_CRM 4'h0
`define SCP_OP1 3'h0
`define SCP_OP2_DATA 3'h0
`define SCP_OP2_INSTR 3'h1

// field positions
`define ERR_CLASS_BIT 12
`define DIR_BIT 11
`define TYPE_HI_BIT 10

// writable masks and reset value
`define DATA_WR_MASK 32'h0000_1c0f
`define INSTR_WR_MASK 32'h0000_140f
`define STATUS_RESET 32'h0000_0000

// fault type codes {bit10, bits3..0}
`define FT_ALIGN 5'h01
`define FT_BACKGROUND 5'h00
`define FT_PERMISSION 5'h0d
`define FT_PRECISE_EXT 5'h08
`define FT_IMPRECISE_EXT 5'h16
`define FT_PRECISE_ECC 5'h19
`define FT_IMPRECISE_ECC 5'h18
`define FT_DEBUG 5'h02

`endif

// ===== hw/abort_status_pkg.sv
`default_nettype none
package abort_status_pkg;

	typedef enum logic [2:0] {
		ABT_ALIGN,
		ABT_BACKGROUND,
		ABT_PERMISSION,
		ABT_PRECISE_EXT,
		ABT_IMPRECISE_EXT,
		ABT_PRECISE_ECC,
		ABT_IMPRECISE_ECC,
		ABT_DEBUG
	} abort_kind_t;

	typedef enum logic [1:0] {
		RESP_OKAY,
		RESP_EXOKAY,
		RESP_SLVERR,
		RESP_DECERR
	} axi_resp_t;

	typedef struct packed {
		logic valid;
		abort_kind_t kind;
		axi_resp_t resp;
		logic excl_read;
		logic is_write;
	} abort_event_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic privileged;
		logic [3:0] cp_num;
		logic [2:0] opc1;
		logic [3:0] crn;
		logic [3:0] crm;
		logic [2:0] opc2;
		logic [31:0] wdata;
	} cp_access_t;

endpackage
`default_nettype wire

// ===== verification/abort_src.sv
`timescale 1ns/100ps
`default_nettype none
module abort_src
	import abort_status_pkg::*;
(
	input wire logic clk_i,
	output abort_event_t ev_o
);
	initial ev_o = '0;
	// one-cycle pulse; released fields flip so stale values never look valid
	task automatic raise(abort_kind_t k, axi_resp_t r, logic x, logic w);
		@(posedge clk_i);
		#2 ev_o = {1'b1, k, r, x, w};
		@(posedge clk_i);
		#2 ev_o = {1'b0, ~ev_o[6:0]};
	endtask
endmodule
`default_nettype wire

// ===== verification/abort_status_sva.sv
`timescale 1ns/100ps
`default_nettype none
module abort_status_sva
	import abort_status_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire abort_event_t data_abort_i,
	input wire abort_event_t instr_abort_i,
	input wire cp_access_t cp_access_i,
	input wire logic cp_accept_o,
	input wire logic cp_refuse_o,
	input wire logic [31:0] cp_rdata_o,
	input wire logic [31:0] data_abort_status_o,
	input wire logic [31:0] instruction_abort_status_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	sequence dhit;
		data_abort_i.valid;
	endsequence
	AST_RAZ: assert property (data_abort_status_o[9:8] == 2'h0)
		else $error("data bits 9:8 set");
	AST_DOM: assert property (((data_abort_status_o | instruction_abort_status_o) & 32'h0000_00f0)
		== 32'h0000_0000) else $error("domain bits set");
	AST_REF: assert property (cp_access_i.valid && !cp_access_i.privileged |-> !cp_accept_o)
		else $error("user access accepted");
	AST_USR: assert property (cp_access_i.valid && !cp_access_i.privileged && cp_access_i.cp_num == 4'hf
		&& cp_access_i.opc1 == 3'h0 && cp_access_i.crn == 4'h5 && cp_access_i.crm == 4'h0
		&& cp_access_i.opc2 inside {3'h0, 3'h1} |-> cp_refuse_o) else $error("user hit not refused");
	AST_RD: assert property (cp_accept_o && !cp_access_i.write && cp_access_i.opc2 == 3'h0
		|=> cp_rdata_o == $past(data_abort_status_o)) else $error("data read value");
	AST_DIR: assert property (dhit |=> data_abort_status_o[11] == $past(data_abort_i.is_write))
		else $error("direction bit wrong");
	AST_NEXT: assert property (dhit ##0 data_abort_i.kind inside {ABT_ALIGN, ABT_DEBUG}
		|=> !data_abort_status_o[12]) else $error("class bit set");
	AST_SLV: assert property (dhit ##0 data_abort_i.resp == RESP_SLVERR
		##0 data_abort_i.kind == ABT_PRECISE_EXT |=> data_abort_status_o[12]) else $error("slave err");
	AST_IALN: assert property (instr_abort_i.valid && instr_abort_i.kind == ABT_ALIGN
		|=> instruction_abort_status_o == 32'h0000_0001) else $error("align code");
	AST_WR: assert property (cp_accept_o && cp_access_i.write && cp_access_i.opc2 == 3'h0
		&& !data_abort_i.valid |=> data_abort_status_o == ($past(cp_access_i.wdata) & 32'h0000_1c0f))
		else $error("write mask");
endmodule
bind abort_fault_status_capture abort_status_sva u_sva (.clk_i, .arst_n_i, .data_abort_i,
	.instr_abort_i, .cp_access_i, .cp_accept_o, .cp_refuse_o, .cp_rdata_o, .data_abort_status_o,
	.instruction_abort_status_o);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import abort_status_pkg::*;
	logic clk_i = 0;
	logic arst_n_i = 0;
	cp_access_t cp_access_i = '0;
	abort_event_t de, ie;
	logic acc, refu;
	logic [31:0] rd, ds, is;
	int bad_count = 0;
	int num_checks = 0;
	logic [4:0] code [8] = '{5'h01, 5'h00, 5'h0d, 5'h08, 5'h16, 5'h19, 5'h18, 5'h02};
	always #12.5 clk_i = ~clk_i;
	abort_src dsrc (.clk_i(clk_i), .ev_o(de));
	abort_src isrc (.clk_i(clk_i), .ev_o(ie));
	abort_fault_status_capture DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .data_abort_i(de),
		.instr_abort_i(ie), .cp_access_i(cp_access_i), .cp_accept_o(acc), .cp_refuse_o(refu),
		.cp_rdata_o(rd), .data_abort_status_o(ds), .instruction_abort_status_o(is));
	task automatic chk(string n, logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic cp(logic w, logic p, logic [3:0] crn, logic [2:0] o2, logic [31:0] d,
		logic ea, logic er);
		@(posedge clk_i);
		#2 cp_access_i = {1'b1, w, p, 4'hf, 3'h0, crn, 4'h0, o2, d};
		#1 chk("accept", {31'h0, acc}, {31'h0, ea});
		chk("refuse", {31'h0, refu}, {31'h0, er});
		@(posedge clk_i);
		#2 cp_access_i.valid = 1'b0;
	endtask
	// every kind once on each side; data write direction alternates with the kind, instruction aborts always raised as writes
	task automatic t_codes;
		logic e;
		for (int k = 0; k < 8; k++)
		begin
			e = (k == 3 || k == 4);
			dsrc.raise(abort_kind_t'(k), RESP_SLVERR, 1'b0, k[0]);
			chk("dcode", ds, {19'h0, e, k[0], code[k][4], 6'h0, code[k][3:0]});
			isrc.raise(abort_kind_t'(k), RESP_SLVERR, 1'b1, 1'b1);
			chk("icode", is, {19'h0, e, 1'b0, code[k][4], 6'h0, code[k][3:0]});
		end
	endtask
	task automatic t_resp;
		dsrc.raise(ABT_PRECISE_EXT, RESP_DECERR, 1'b0, 1'b0);
		chk("decerr", ds, 32'h0000_0008);
		dsrc.raise(ABT_IMPRECISE_EXT, RESP_OKAY, 1'b1, 1'b0);
		chk("excl", ds, 32'h0000_1406);
	endtask
	task automatic t_regs;
		cp(1'b1, 1'b1, 4'h5, 3'h0, 32'hffff_ffff, 1'b1, 1'b0);
		chk("dwr", ds, 32'h0000_1c0f);
		cp(1'b1, 1'b1, 4'h5, 3'h1, 32'hffff_ffff, 1'b1, 1'b0);
		chk("iwr", is, 32'h0000_140f);
		cp(1'b1, 1'b0, 4'h5, 3'h0, 32'h0000_0000, 1'b0, 1'b1);
		chk("user", ds, 32'h0000_1c0f);
		cp(1'b1, 1'b1, 4'h6, 3'h0, 32'h0000_0000, 1'b0, 1'b0);
		cp(1'b0, 1'b1, 4'h5, 3'h0, 32'h0000_0000, 1'b1, 1'b0);
		chk("drd", rd, 32'h0000_1c0f);
		cp(1'b0, 1'b1, 4'h5, 3'h1, 32'h0000_0000, 1'b1, 1'b0);
		chk("ird", rd, 32'h0000_140f);
		cp(1'b0, 1'b0, 4'h5, 3'h0, 32'h0000_0000, 1'b0, 1'b1);
		chk("urd", rd, 32'h0000_140f);
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		repeat (10) @(posedge clk_i);
		#2 arst_n_i = 1'b1;
		chk("rst", ds, 32'h0000_0000);
		t_regs();
		t_codes();
		t_resp();
		final_report();
	end
endmodule
`default_nettype wire
